/* design/sfh_map.svh */
// Register offsets, field positions, opcodes and timing counts of the flash host
`ifndef SFH_MAP_SVH
`define SFH_MAP_SVH
// APB register byte offsets
`define SFH_CTRL_OFS      12'h000
`define SFH_ADDR_OFS      12'h004
`define SFH_WDATA_OFS     12'h008
`define SFH_STATUS_OFS    12'h00C
`define SFH_RDATA_OFS     12'h010
// Control word fields; the last-byte flag is taken from writes to the write-data register
`define SFH_CTRL_GO_BIT   31
`define SFH_CTRL_LAST_BIT 30
`define SFH_CTRL_CMD_LSB  0
`define SFH_CTRL_CMD_MSB  3
`define SFH_CTRL_MODE_LSB 8
`define SFH_CTRL_MODE_MSB 15
// Status word fields
`define SFH_ST_BUSY_BIT   0
`define SFH_ST_WREQ_BIT   1
`define SFH_ST_CONT_BIT   2
// Flash opcodes
`define SFH_OP_WRITE_ENABLE_CMD       8'h06
`define SFH_OP_QREAD      8'hEB
`define SFH_OP_WRAP       8'h77
`define SFH_OP_PAGE_ERASE 8'h81
`define SFH_OP_SECT_ERASE 8'h20
`define SFH_OP_HALF_BLOCK 8'h52
`define SFH_OP_BLOCK      8'hD8
`define SFH_OP_CHIP       8'hC7
`define SFH_OP_PROG       8'h02
`define SFH_OP_RDSR       8'h05
`define SFH_OP_MODE_RST   8'hFF
// Continuous-read mode byte values
`define SFH_MODE_CONT     8'h20
`define SFH_MODE_EXIT     8'h00
// Wrap-off setting, W4 set
`define SFH_WRAP_OFF      8'h10
// Last divider count of a serial clock half period, which lasts 4 pclk cycles
`define SFH_HALF_DIV      4'h3
// Busy flag bit in device status
`define SFH_WIP_BIT       0
`endif

/* design/sfh_pkg.sv */
// Types shared by the serial flash host controller
package sfh_pkg;
  typedef enum logic [3:0] {
    SFH_CMD_WRITE_ENABLE_CMD, SFH_CMD_QREAD, SFH_CMD_WRAP, SFH_CMD_PERASE, SFH_CMD_SERASE,
    SFH_CMD_HBERASE, SFH_CMD_BERASE, SFH_CMD_CERASE, SFH_CMD_PROG, SFH_CMD_RDSR,
    SFH_CMD_MRST
  } sfh_cmd_t;
  typedef enum logic [2:0] {
    SFH_IDLE, SFH_SHIFT, SFH_WAITDATA, SFH_READ, SFH_GAP
  } sfh_state_t;
  // Pins toward the flash, output enables low while driving
  typedef struct packed {
    logic       cs_n;
    logic       sck;
    logic [3:0] io_out;
    logic [3:0] io_oe_n;
  } sfh_pins_t;
endpackage : sfh_pkg

/* design/sfh_host.sv */
// Serial flash host: APB command registers driving a quad serial NOR flash
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "sfh_map.svh"
module sfh_host
  import sfh_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Flash pins
  output logic             flash_cs_n,
  output logic             flash_sck,
  output logic      [3:0]  flash_io_out,
  output logic      [3:0]  flash_io_oe_n,
  input  wire logic [3:0]  flash_io_in
);
  typedef struct packed {
    sfh_state_t  st;
    sfh_pins_t   pins;
    logic [3:0]  div;
    logic [55:0] sh;        // Outgoing bits, MSB first
    logic [6:0]  bits;      // Serial clocks left in this segment
    logic        quad;      // Segment shifted four bits per clock
    logic        quad_tail; // Address in quad mode follows opcode
    logic [3:0]  dummy;     // Quad dummy clocks left before data
    logic [31:0] addr;
    logic [7:0]  mode;
    logic [7:0]  wdata;
    logic        wvalid;    // Software has supplied next program byte
    logic        last;      // Pending program byte is the final one
    logic        done;      // No program byte follows; deselect at the next pause
    logic        cont;      // Device sits in continuous read
    logic [7:0]  rdata;
    logic [3:0]  rcnt;
    logic        sck_q;
    logic [3:0]  io_s1;
    logic [3:0]  io_s2;
  } sfh_regs_t;
  sfh_regs_t r, next_r;
  logic wr_acc, rd_acc;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign flash_cs_n = r.pins.cs_n;
  assign flash_sck = r.pins.sck;
  assign flash_io_out = r.pins.io_out;
  assign flash_io_oe_n = r.pins.io_oe_n;

  // Pack opcode, address and mode byte into the 56-bit shifter, MSB first
  function automatic logic [55:0] sfh_pack(input logic [7:0] op, input logic [23:0] a, input logic [7:0] m);
    sfh_pack = {op, a, m, 16'h0000};
  endfunction : sfh_pack

  // Register read mux
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      `SFH_ADDR_OFS:   prdata = r.addr;
      `SFH_WDATA_OFS:  prdata = {24'h000000, r.wdata};
      `SFH_STATUS_OFS: prdata = {29'h0, r.cont, ~r.wvalid & ~r.done & (r.st != SFH_IDLE), r.st != SFH_IDLE};
      `SFH_RDATA_OFS:  prdata = {24'h000000, r.rdata};
      default:         prdata = 32'h0000_0000;
    endcase
  end

  // Next-state logic: command start, bit shifter, sampling
  always_comb begin
    sfh_cmd_t cmd;
    logic     rise, fall;
    next_r = r;
    cmd = sfh_cmd_t'(pwdata[`SFH_CTRL_CMD_MSB:`SFH_CTRL_CMD_LSB]);
    next_r.io_s1 = flash_io_in;
    next_r.io_s2 = r.io_s1;
    rise = 1'b0;
    fall = 1'b0;
    if (wr_acc && paddr == `SFH_ADDR_OFS) next_r.addr = pwdata;
    if (wr_acc && paddr == `SFH_WDATA_OFS) begin
      next_r.wdata = pwdata[7:0];
      next_r.wvalid = 1'b1;
      next_r.last = pwdata[`SFH_CTRL_LAST_BIT];
    end
    // Clock divider runs only while a segment is active
    if (r.st == SFH_SHIFT || r.st == SFH_READ) begin
      if (r.div == `SFH_HALF_DIV) begin
        next_r.div = 4'h0;
        next_r.pins.sck = ~r.pins.sck;
        rise = ~r.pins.sck;
        fall = r.pins.sck;
      end else begin
        next_r.div = r.div + 4'h1;
      end
    end
    unique case (r.st)
      SFH_IDLE: begin
        if (wr_acc && paddr == `SFH_CTRL_OFS && pwdata[`SFH_CTRL_GO_BIT]) begin
          next_r.pins.cs_n = 1'b0;
          next_r.pins.io_oe_n = 4'hE;
          next_r.quad = 1'b0;
          next_r.quad_tail = 1'b0;
          next_r.dummy = 4'h0;
          next_r.st = SFH_SHIFT;
          next_r.div = 4'h0;
          next_r.mode = pwdata[`SFH_CTRL_MODE_MSB:`SFH_CTRL_MODE_LSB];
          unique case (cmd)
            SFH_CMD_WRITE_ENABLE_CMD: begin next_r.sh = sfh_pack(`SFH_OP_WRITE_ENABLE_CMD, 24'h0, 8'h00); next_r.bits = 7'd8; end
            // Opcode only, deselect straight after
            SFH_CMD_CERASE: begin next_r.sh = sfh_pack(`SFH_OP_CHIP, 24'h0, 8'h00); next_r.bits = 7'd8; end
            SFH_CMD_MRST: begin next_r.sh = {56{1'b1}}; next_r.bits = 7'd8; end
            SFH_CMD_RDSR: begin next_r.sh = sfh_pack(`SFH_OP_RDSR, 24'h0, 8'h00); next_r.bits = 7'd8; end
            SFH_CMD_WRAP: begin next_r.sh = sfh_pack(`SFH_OP_WRAP, 24'h0, pwdata[23:16]); next_r.bits = 7'd40; end
            SFH_CMD_PERASE: begin
              next_r.sh = sfh_pack(`SFH_OP_PAGE_ERASE, {r.addr[23:8], 8'h00}, 8'h00);
              next_r.bits = 7'd32;
            end
            SFH_CMD_SERASE: begin next_r.sh = sfh_pack(`SFH_OP_SECT_ERASE, r.addr[23:0], 8'h00); next_r.bits = 7'd32; end
            SFH_CMD_HBERASE: begin next_r.sh = sfh_pack(`SFH_OP_HALF_BLOCK, r.addr[23:0], 8'h00); next_r.bits = 7'd32; end
            SFH_CMD_BERASE: begin next_r.sh = sfh_pack(`SFH_OP_BLOCK, r.addr[23:0], 8'h00); next_r.bits = 7'd32; end
            SFH_CMD_PROG: begin next_r.sh = sfh_pack(`SFH_OP_PROG, r.addr[23:0], 8'h00); next_r.bits = 7'd32; end
            default: begin // Quad read, opcode dropped in continuous mode
              next_r.mode = (pwdata[`SFH_CTRL_MODE_MSB:`SFH_CTRL_MODE_LSB] == `SFH_MODE_CONT) ?
                            `SFH_MODE_CONT : `SFH_MODE_EXIT;
              next_r.quad_tail = 1'b1;
              if (r.cont) begin
                next_r.sh = {r.addr[23:0], next_r.mode, 24'h000000};
                next_r.bits = 7'd8;
                next_r.quad = 1'b1;
                next_r.pins.io_oe_n = 4'h0;
                next_r.quad_tail = 1'b0;
              end else begin
                next_r.sh = sfh_pack(`SFH_OP_QREAD, 24'h0, 8'h00);
                next_r.bits = 7'd8;
              end
              next_r.dummy = 4'h4;
              next_r.cont = (next_r.mode == `SFH_MODE_CONT);
            end
          endcase
          if (cmd == SFH_CMD_MRST) next_r.cont = 1'b0;
          next_r.pins.io_out = {3'b000, next_r.sh[55]};
          if (next_r.quad) next_r.pins.io_out = next_r.sh[55:52];
          next_r.rcnt = (cmd == SFH_CMD_RDSR || cmd == SFH_CMD_QREAD) ? 4'h8 : 4'h0;
          next_r.wvalid = (cmd == SFH_CMD_PROG) ? 1'b0 : r.wvalid;
          // Only program frames wait for data bytes; all others end after their last segment, or after the read byte for status and quad reads
          next_r.done = (cmd != SFH_CMD_PROG);
        end
      end
      SFH_SHIFT: begin
        // Drive on falling edge, device samples on rising
        if (rise) next_r.bits = r.bits - 7'd1;
        if (fall) begin
          next_r.sh = r.quad ? {r.sh[51:0], 4'h0} : {r.sh[54:0], 1'b0};
          next_r.pins.io_out = r.quad ? r.sh[51:48] : {3'b000, r.sh[54]};
          if (r.bits == 7'd0) begin
            if (r.quad_tail) begin // Address and mode on four lines
              next_r.quad = 1'b1;
              next_r.quad_tail = 1'b0;
              next_r.pins.io_oe_n = 4'h0;
              next_r.sh = {r.addr[23:0], r.mode, 24'h000000};
              next_r.pins.io_out = r.addr[23:20];
              next_r.bits = 7'd8;
            end else if (r.rcnt != 4'h0) begin
              next_r.pins.io_oe_n = r.quad ? 4'hF : 4'hE;
              next_r.st = SFH_READ;
            end else begin
              next_r.st = SFH_WAITDATA;
              next_r.pins.sck = 1'b0;
            end
          end
        end
      end
      SFH_WAITDATA: begin
        // Program bytes stream in from software; deselect only after whole bytes
        if (r.done) begin
          next_r.pins.cs_n = 1'b1;
          next_r.pins.io_oe_n = 4'hF;
          next_r.st = SFH_GAP;
        end else if (r.wvalid) begin
          next_r.sh = {r.wdata, 48'h0};
          next_r.pins.io_out = {3'b000, r.wdata[7]};
          next_r.bits = 7'd8;
          // A byte written in this very cycle stays pending: set wins over clear
          next_r.wvalid = wr_acc && paddr == `SFH_WDATA_OFS;
          next_r.done = r.last;
          next_r.st = SFH_SHIFT;
        end
      end
      SFH_READ: begin
        if (r.dummy != 4'h0 && rise) next_r.dummy = r.dummy - 4'h1;
        else if (rise) begin
          next_r.rdata = r.quad ? {r.rdata[3:0], r.io_s2} : {r.rdata[6:0], r.io_s2[1]};
          next_r.rcnt = r.quad ? ((r.rcnt > 4'h4) ? r.rcnt - 4'h4 : 4'h0) : r.rcnt - 4'h1;
        end
        if (r.rcnt == 4'h0 && !r.pins.sck) begin
          next_r.pins.cs_n = 1'b1;
          next_r.st = SFH_GAP;
        end
      end
      SFH_GAP: begin
        next_r.pins.sck = 1'b0;
        next_r.st = SFH_IDLE;
      end
      default: next_r.st = SFH_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= SFH_IDLE;
      r.pins.cs_n <= 1'b1;
      r.pins.io_oe_n <= 4'hF;
    end else begin
      r <= next_r;
    end
  end

  // Checks
  a_cs_high_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == SFH_IDLE) |-> flash_cs_n) else $error("chip select low while idle");
  a_busy_gap_ends: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == SFH_GAP) |=> (r.st == SFH_IDLE) && flash_cs_n) else $error("gap not one cycle");
  a_wait_deselect: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == SFH_WAITDATA && r.done) |=> flash_cs_n) else $error("no deselect after byte");
  a_mrst_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == SFH_IDLE && wr_acc && paddr == `SFH_CTRL_OFS && pwdata[31] && pwdata[3:0] == 4'hA) |=> !r.cont)
    else $error("mode reset left continuous");
  a_sck_low_sel: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(flash_cs_n) |-> !flash_sck) else $error("clock high at select");
  a_upper_off: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == SFH_SHIFT && !r.quad) |-> flash_io_oe_n[3:1] == 3'b111) else $error("upper lines driven");
  a_shift_sel: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == SFH_SHIFT) |-> !flash_cs_n) else $error("shift while deselected");
  a_pready_one: assert property (@(posedge pclk) disable iff (!presetn)
    psel |-> pready) else $error("slave stalled");
  c_prog: cover property (@(posedge pclk) disable iff (!presetn) r.st == SFH_WAITDATA ##1 r.st == SFH_SHIFT);
  c_read: cover property (@(posedge pclk) disable iff (!presetn) r.st == SFH_READ ##1 r.st == SFH_GAP);
  c_cont: cover property (@(posedge pclk) disable iff (!presetn) $rose(r.cont));
endmodule : sfh_host
`default_nettype wire

/* bench/sfh_flash_model.sv */
// Behavioural serial NOR flash answering the host on its pins
`timescale 1ns/1ns
`default_nettype none
module sfh_flash_model #(parameter int BUSY_CYC = 30, parameter int MEM_BYTES = 65536) (
  // Clock for self-timed cycles
  input  wire logic       pclk,
  // Serial pins
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic [3:0] io,
  output logic      [3:0] dev_out,
  output logic      [3:0] dev_oe,
  // Nonzero blocks every erase of the array but not programming, kept simple on purpose
  input  wire logic [4:0] protect_sel
);
  logic [7:0]  mem [MEM_BYTES];
  logic [7:0]  op, wrap_bits, st, off, q[$];
  logic [31:0] sh, a;
  logic        cont, write_enable_latch, write_in_progress, go;
  int          cnt, nib, drop;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    {op, sh, a, cont, write_enable_latch, write_in_progress} = '0;
    dev_oe = 4'h0;
    dev_out = 4'h0;
    wrap_bits = 8'h10;
  end
  task automatic erase(input int base, input int size);
    if (protect_sel == 5'h00)
      for (int i = 0; i < size; i++) mem[(base + i) % MEM_BYTES] = 8'hFF;
  endtask : erase
  // Frame start; continuous mode skips the opcode
  always @(negedge cs_n) begin
    cnt = 0;
    nib = 0;
    drop = 0;
    q = {};
    op = cont ? 8'hEB : 8'h00;
  end
  // Sample on the rising serial clock
  always @(posedge sck) if (!cs_n) begin
    if (op == 8'hEB) begin
      sh = {sh[27:0], io};
      nib++;
      if (nib == 6) a = {8'h00, sh[23:0]};
      if (nib == 8) cont = (sh[5:4] == 2'b10);
    end else begin
      sh = {sh[30:0], io[0]};
      cnt++;
      if (cnt == 8) op = sh[7:0];
      if (cnt == 32) a = {8'h00, sh[23:0]};
      if (op == 8'h02 && cnt > 32 && cnt % 8 == 0) begin
        q.push_back(sh[7:0]);
        if (q.size() > 256) begin
          void'(q.pop_front());
          drop++;
        end
      end
    end
  end
  // Drive answers after the falling serial clock
  always @(negedge sck) if (!cs_n) begin
    st = {6'h00, write_enable_latch, write_in_progress};
    if (op == 8'hEB && nib >= 12) begin
      dev_oe = 4'hF;
      dev_out = (nib == 12) ? mem[a % MEM_BYTES][7:4] : mem[a % MEM_BYTES][3:0];
    end
    if (op == 8'h05 && cnt >= 8) begin
      dev_oe = 4'h2;
      dev_out = {2'b00, st[7 - (cnt - 8) % 8], 1'b0};
    end
  end
  // Commands act when select rises
  always @(posedge cs_n) begin
    dev_oe = 4'h0;
    go = 1'b1;
    if (op == 8'h06 && cnt == 8) write_enable_latch = 1'b1;
    if (op == 8'hFF) cont = 1'b0;
    if (op == 8'h77 && cnt == 40) wrap_bits = sh[7:0];
    if (!write_enable_latch || write_in_progress || cnt % 8 != 0) go = 1'b0;
    else if (op == 8'h81 && cnt == 32) erase(a & 32'hFFFF00, 256);
    else if (op == 8'h20 && cnt == 32) erase(a & 32'hFFF000, 4096);
    else if (op == 8'h52 && cnt == 32) erase(a & 32'hFF8000, 32768);
    else if (op == 8'hD8 && cnt == 32) erase(a & 32'hFF0000, 65536);
    else if ((op == 8'hC7 || op == 8'h60) && cnt == 8) erase(0, MEM_BYTES);
    else if (op == 8'h02 && cnt > 32) begin
      foreach (q[i]) begin
        off = a[7:0] + drop[7:0] + i[7:0];
        mem[{a[23:8], off} % MEM_BYTES] &= q[i];
      end
    end else go = 1'b0;
    if (go) begin
      write_in_progress = 1'b1;
      fork
        begin
          repeat (BUSY_CYC) @(posedge pclk);
          write_in_progress = 1'b0;
          write_enable_latch = 1'b0;
        end
      join_none
    end
  end
endmodule : sfh_flash_model
`default_nettype wire

/* bench/sfh_host_test.sv */
// Self-checking bench: APB sequences through the host into a behavioural flash
`timescale 1ns/1ns
`default_nettype none
`include "sfh_map.svh"
module sfh_host_test;
  import sfh_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cs_n, sck;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  io_out, io_oe_n, dev_out, dev_oe, io;
  logic [4:0]  protect_sel;
  int          errors, n_checks, cycles;
  // Shared lines: host drives when enable low, else flash, else pull-up
  always_comb for (int i = 0; i < 4; i++) io[i] = !io_oe_n[i] ? io_out[i] : dev_oe[i] ? dev_out[i] : 1'b1;
  sfh_host dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_cs_n(cs_n),
    .flash_sck(sck), .flash_io_out(io_out), .flash_io_oe_n(io_oe_n), .flash_io_in(io));
  sfh_flash_model flash_u (.pclk(pclk), .cs_n(cs_n), .sck(sck), .io(io), .dev_out(dev_out),
    .dev_oe(dev_oe), .protect_sel(protect_sel));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // Hang guard, well above the longest program sequence
  initial begin
    cycles = 0;
    forever begin
      @(posedge pclk);
      cycles++;
      if (cycles == 80000) begin
        errors++;
        report_and_stop();
      end
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One APB transfer: setup, then access held until pready
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_idle;
    do apb(1'b0, `SFH_STATUS_OFS, 32'h0); while (rd[`SFH_ST_BUSY_BIT] !== 1'b0);
  endtask : wait_idle
  task automatic cmd(input sfh_cmd_t c, input logic [31:0] a = 0, input logic [7:0] m = 0, input logic [7:0] w = 0);
    apb(1'b1, `SFH_ADDR_OFS, a);
    apb(1'b1, `SFH_CTRL_OFS, {1'b1, 7'h00, w, m, 4'h0, c});
    wait_idle();
  endtask : cmd
  task automatic flash_st;
    cmd(SFH_CMD_RDSR);
    apb(1'b0, `SFH_RDATA_OFS, 32'h0);
  endtask : flash_st
  // Software polls the flash busy flag, the host does not
  task automatic wait_flash;
    do flash_st(); while (rd[`SFH_WIP_BIT] !== 1'b0);
  endtask : wait_flash
  task automatic prog(input logic [31:0] a, input int n, input logic [7:0] b);
    apb(1'b1, `SFH_ADDR_OFS, a);
    apb(1'b1, `SFH_CTRL_OFS, {28'h8000000, SFH_CMD_PROG});
    for (int i = 0; i < n; i++) begin
      do apb(1'b0, `SFH_STATUS_OFS, 32'h0); while (rd[`SFH_ST_WREQ_BIT] !== 1'b1);
      apb(1'b1, `SFH_WDATA_OFS, {1'b0, i == n - 1, 22'h0, (b + i[7:0]) ^ {7'h00, i[8]}});
    end
    wait_idle();
  endtask : prog
  task automatic we(input logic [31:0] a, input logic [7:0] v);
    cmd(SFH_CMD_WRITE_ENABLE_CMD);
    prog(a, 1, v);
    wait_flash();
  endtask : we
  task automatic ers(input sfh_cmd_t c, input logic [31:0] a);
    cmd(SFH_CMD_WRITE_ENABLE_CMD);
    cmd(c, a);
    wait_flash();
  endtask : ers
  task automatic rchk(input string w, input logic [31:0] a, input logic [7:0] e, input logic [7:0] m = 0);
    cmd(SFH_CMD_QREAD, a, m);
    apb(1'b0, `SFH_RDATA_OFS, 32'h0);
    check(w, rd[7:0], e);
  endtask : rchk
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    protect_sel = 5'h00;
    errors = 0;
    n_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    prog(32'h100, 1, 8'h5A);
    rchk("unlatched program", 32'h100, 8'hFF);
    cmd(SFH_CMD_WRITE_ENABLE_CMD);
    flash_st();
    check("latch set", rd[7:0], 8'h02);
    prog(32'h1FE, 3, 8'h30);
    wait_flash();
    check("latch cleared", rd[7:0], 8'h00);
    rchk("short program", 32'h1FF, 8'h31);
    rchk("page wrap", 32'h100, 8'h32);
    ers(SFH_CMD_PERASE, 32'h155);
    rchk("page erase", 32'h1FE, 8'hFF);
    we(32'h2345, 8'h11);
    ers(SFH_CMD_SERASE, 32'h2ABC);
    rchk("sector erase", 32'h2345, 8'hFF);
    we(32'h8000, 8'h44);
    protect_sel <= 5'h04;
    ers(SFH_CMD_HBERASE, 32'h8123);
    check("protected latch", rd[7:0], 8'h00);
    rchk("protected block", 32'h8000, 8'h44);
    ers(SFH_CMD_CERASE, 32'h0);
    rchk("protected chip", 32'h8000, 8'h44);
    protect_sel <= 5'h00;
    ers(SFH_CMD_CERASE, 32'h0);
    rchk("chip erase", 32'h8000, 8'hFF);
    we(32'hA000, 8'h66);
    ers(SFH_CMD_HBERASE, 32'hA7FF);
    rchk("half block", 32'hA000, 8'hFF);
    we(32'h9000, 8'h77);
    ers(SFH_CMD_BERASE, 32'h9ABC);
    rchk("block erase", 32'h9000, 8'hFF);
    cmd(SFH_CMD_WRITE_ENABLE_CMD);
    prog(32'h300, 258, 8'h00);
    wait_flash();
    rchk("last bytes kept", 32'h300, 8'h01);
    rchk("continuous entry", 32'h302, 8'h02, 8'h20);
    apb(1'b0, `SFH_STATUS_OFS, 32'h0);
    check("continuous flag", rd[`SFH_ST_CONT_BIT], 1'b1);
    rchk("opcode skipped", 32'h303, 8'h03);
    check("continuous left", flash_u.cont, 1'b0);
    rchk("continuous again", 32'h304, 8'h04, 8'h20);
    cmd(SFH_CMD_MRST);
    check("mode reset", flash_u.cont, 1'b0);
    rchk("normal read", 32'h305, 8'h05);
    cmd(SFH_CMD_WRAP, 32'h0, 8'h00, 8'h40);
    check("wrap set", flash_u.wrap_bits, 8'h40);
    cmd(SFH_CMD_WRAP, 32'h0, 8'h00, `SFH_WRAP_OFF);
    check("wrap off", flash_u.wrap_bits, 8'h10);
    report_and_stop();
  end
endmodule : sfh_host_test
`default_nettype wire
